// File: pkg/srw_defines.svh
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH

// Clock period of clk_in in nanoseconds (20 MHz)
`define SRW_CLK_PERIOD_NS 50
// Active pull-up one-shot time in nanoseconds
`define SRW_ONESHOT_NS 2000
// One-shot in cycles, longest time so rounded down
`define SRW_ONESHOT_CYC ((`SRW_ONESHOT_NS) / (`SRW_CLK_PERIOD_NS))
// Reset hold period in microseconds (shortest option)
`define SRW_HOLD_US 1000
// Watchdog period in microseconds (shortest option)
`define SRW_WD_US 6300
// Periods in cycles
`define SRW_HOLD_CYC ((`SRW_HOLD_US) * 1000 / (`SRW_CLK_PERIOD_NS))
`define SRW_WD_CYC ((`SRW_WD_US) * 1000 / (`SRW_CLK_PERIOD_NS))
// Floating kick input is serviced at 7/8 of the watchdog period
`define SRW_FLOAT_NUM 7
`define SRW_FLOAT_DEN 8
// Output style codes
`define SRW_STYLE_PP 2'h0
`define SRW_STYLE_OD 2'h1
`define SRW_STYLE_BIDIR 2'h2

`endif

// File: pkg/srw_pkg.sv
package srw_pkg;

   // Supervisor sequence states
   typedef enum logic [2:0] {
      SRW_ST_RUN = 3'h1,
      SRW_ST_FORCE = 3'h2,
      SRW_ST_HOLD = 3'h4
   } srw_state_e;

   // Counter module state
   typedef struct packed {
      logic [31:0] cnt;
      logic hit;
   } srw_tmr_s;

   // Supervisor core state
   typedef struct packed {
      srw_state_e st;
      logic uv_s1;
      logic uv_s2;
      logic mr_s1;
      logic mr_s2;
      logic kick_s1;
      logic kick_s2;
      logic kick_s3;
      logic flt_s1;
      logic flt_s2;
      logic pth_s1;
      logic pth_s2;
      logic hi_s1;
      logic hi_s2;
      logic trans;
      logic pu;
      logic rstn_o;
      logic rst_o;
      logic line_o;
      logic line_oe;
      logic passive_o;
   } srw_core_s;

endpackage : srw_pkg

// File: core/srw_timer.sv
`timescale 1ns/10ps
module srw_timer
   import srw_pkg::*;
#(
   parameter logic [31:0] LIMIT = 32'h0000_0010
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic clr_in,
   output logic [31:0] cnt_out,
   output logic hit_out
);
   srw_tmr_s q;
   srw_tmr_s d;

   // Count up, saturate at LIMIT, restart on clear
   always_comb begin
      d = q;
      if (clr_in) begin
         d.cnt = 32'h0000_0000;
      end else if (q.cnt != LIMIT) begin
         d.cnt = q.cnt + 32'h0000_0001;
      end
      d.hit = (d.cnt == LIMIT);
   end

   // State register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cnt_out = q.cnt;
   assign hit_out = q.hit;
endmodule : srw_timer

// File: core/srw_core.sv
`include "srw_defines.svh"
`timescale 1ns/10ps
module srw_core
   import srw_pkg::*;
#(
   parameter logic [1:0] OUT_STYLE = `SRW_STYLE_PP,
   parameter logic [31:0] HOLD_CYC = `SRW_HOLD_CYC,
   parameter logic [31:0] WD_CYC = `SRW_WD_CYC
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic undervoltage_in,
   input wire logic manual_reset_n_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_float_in,
   input wire logic line_above_pth_in,
   input wire logic line_above_hi_in,
   output logic reset_n_out,
   output logic reset_out,
   output logic line_out,
   output logic line_oe_out,
   output logic passive_pullup_out
);

   // Floating-service point and one-shot length
   localparam logic [31:0] WD_FLOAT_CYC =
      32'(64'(WD_CYC) * `SRW_FLOAT_NUM / `SRW_FLOAT_DEN);
   // Pull-up drops one cycle after the hit, so the one-shot limit is one short
   localparam logic [31:0] OS_CYC = 32'(`SRW_ONESHOT_CYC) - 32'h0000_0001;
   localparam logic IS_BIDIR = (OUT_STYLE == `SRW_STYLE_BIDIR);

   srw_core_s q;
   srw_core_s d;

   logic [31:0] wd_cnt;
   logic wd_hit;
   logic wd_clr;
   logic hold_hit;
   logic hold_clr;
   logic os_hit;
   logic os_clr;
   logic cause;
   logic kick_edge;
   logic ext_low;
   logic wd_expire;

   // Watchdog counter
   srw_timer #(
      .LIMIT(WD_CYC)
   ) u_wd (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .clr_in(wd_clr),
      .cnt_out(wd_cnt),
      .hit_out(wd_hit)
   );

   // Reset hold counter
   srw_timer #(
      .LIMIT(HOLD_CYC)
   ) u_hold (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .clr_in(hold_clr),
      .cnt_out(),
      .hit_out(hold_hit)
   );

   // Active pull-up one-shot
   srw_timer #(
      .LIMIT(OS_CYC)
   ) u_os (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .clr_in(os_clr),
      .cnt_out(),
      .hit_out(os_hit)
   );

   // Level reset causes and watchdog events
   always_comb begin
      cause = q.uv_s2 | ~q.mr_s2;
      kick_edge = q.kick_s2 ^ q.kick_s3;
      ext_low = IS_BIDIR & q.rstn_o & ~q.pth_s2;
      wd_expire = wd_hit & ~q.flt_s2;
   end

   // Counter clears
   always_comb begin
      wd_clr = (q.st != SRW_ST_RUN)
         | (kick_edge & ~q.flt_s2)
         | ext_low
         | (q.flt_s2 & (wd_cnt >= WD_FLOAT_CYC));
      hold_clr = (q.st != SRW_ST_HOLD);
      os_clr = ~q.pu;
   end

   // Next state of the supervisor
   always_comb begin
      d = q;
      // Two-flop synchronisers for the pins
      d.uv_s1 = undervoltage_in;
      d.uv_s2 = q.uv_s1;
      d.mr_s1 = manual_reset_n_in;
      d.mr_s2 = q.mr_s1;
      d.kick_s1 = watchdog_kick_in;
      d.kick_s2 = q.kick_s1;
      d.kick_s3 = q.kick_s2; // Edge history
      d.flt_s1 = watchdog_float_in;
      d.flt_s2 = q.flt_s1;
      d.pth_s1 = line_above_pth_in;
      d.pth_s2 = q.pth_s1;
      d.hi_s1 = line_above_hi_in;
      d.hi_s2 = q.hi_s1;

      // Reset sequence
      case (q.st)
         SRW_ST_RUN: begin
            if (cause) begin
               d.st = SRW_ST_FORCE;
            end else if (wd_expire) begin
               d.st = SRW_ST_HOLD;
            end
         end
         SRW_ST_FORCE: begin
            if (!cause) begin
               d.st = SRW_ST_HOLD;
            end
         end
         SRW_ST_HOLD: begin
            if (cause) begin
               d.st = SRW_ST_FORCE;
            end else if (hold_hit) begin
               d.st = SRW_ST_RUN;
            end
         end
         default: begin
            d.st = SRW_ST_HOLD;
         end
      endcase

      // Reset outputs from the same next state
      d.rstn_o = (d.st == SRW_ST_RUN);
      d.rst_o = ~d.rstn_o;

      // Transition flip-flop and active pull-up, any reset source
      if (IS_BIDIR) begin
         if (!q.pth_s2) begin
            d.trans = 1'b1;
         end
         if (q.pu) begin
            if (q.hi_s2 || os_hit || !d.rstn_o) begin
               d.pu = 1'b0;
            end
         end else if (q.trans && q.rstn_o && d.rstn_o
                      && q.pth_s2 && !q.hi_s2) begin
            d.pu = 1'b1;
            d.trans = 1'b0;
         end
      end else begin
         d.trans = 1'b0;
         d.pu = 1'b0;
      end

      // Pin drive per output style
      case (OUT_STYLE)
         `SRW_STYLE_OD: begin
            d.line_o = 1'b0;
            d.line_oe = ~d.rstn_o;
         end
         `SRW_STYLE_BIDIR: begin
            d.line_o = d.rstn_o;
            d.line_oe = ~d.rstn_o | d.pu;
         end
         default: begin
            d.line_o = d.rstn_o;
            d.line_oe = 1'b1;
         end
      endcase
      d.passive_o = IS_BIDIR & d.rstn_o;
   end

   // State register, reset asserted from power-up
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q.st <= SRW_ST_HOLD;
         q.uv_s1 <= 1'b0;
         q.uv_s2 <= 1'b0;
         q.mr_s1 <= 1'b1;
         q.mr_s2 <= 1'b1;
         q.kick_s1 <= 1'b0;
         q.kick_s2 <= 1'b0;
         q.kick_s3 <= 1'b0;
         q.flt_s1 <= 1'b0;
         q.flt_s2 <= 1'b0;
         q.pth_s1 <= 1'b0;
         q.pth_s2 <= 1'b0;
         q.hi_s1 <= 1'b0;
         q.hi_s2 <= 1'b0;
         q.trans <= 1'b1;
         q.pu <= 1'b0;
         q.rstn_o <= 1'b0;
         q.rst_o <= 1'b1;
         q.line_o <= 1'b0;
         q.line_oe <= 1'b1;
         q.passive_o <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state flops
   assign reset_n_out = q.rstn_o;
   assign reset_out = q.rst_o;
   assign line_out = q.line_o;
   assign line_oe_out = q.line_oe;
   assign passive_pullup_out = q.passive_o;

   // Complementary outputs
   property p_complement;
      @(posedge clk_in) disable iff (!rstn_in)
      reset_out == !reset_n_out;
   endproperty
   a_complement: assert property (p_complement)
      else $error("reset_out is not the complement of reset_n_out");

   // Manual reset low forces reset next cycle
   property p_mr_low;
      @(posedge clk_in) disable iff (!rstn_in)
      !q.mr_s2 |=> (q.st == SRW_ST_FORCE) && !reset_n_out;
   endproperty
   a_mr_low: assert property (p_mr_low)
      else $error("manual reset low did not force reset");

   // Release of manual reset starts the hold period
   property p_mr_hold;
      @(posedge clk_in) disable iff (!rstn_in)
      (q.st == SRW_ST_FORCE) && q.mr_s2 && !q.uv_s2
         |=> (q.st == SRW_ST_HOLD) [*2];
   endproperty
   a_mr_hold: assert property (p_mr_hold)
      else $error("cause release did not enter the hold period");

   // Watchdog expiry moves to hold
   property p_wd_expire;
      @(posedge clk_in) disable iff (!rstn_in)
      (q.st == SRW_ST_RUN) && wd_hit && !q.flt_s2 && !cause
         |=> (q.st == SRW_ST_HOLD) && !reset_n_out;
   endproperty
   a_wd_expire: assert property (p_wd_expire)
      else $error("watchdog expiry did not assert reset");

   // Counter cleared while reset is asserted
   property p_wd_clear;
      @(posedge clk_in) disable iff (!rstn_in)
      (q.st != SRW_ST_RUN) |=> (wd_cnt == 32'h0000_0000);
   endproperty
   a_wd_clear: assert property (p_wd_clear)
      else $error("watchdog counter not cleared during reset");

   // Kick edge clears the counter
   property p_kick;
      @(posedge clk_in) disable iff (!rstn_in)
      kick_edge && !q.flt_s2 |=> (wd_cnt == 32'h0000_0000);
   endproperty
   a_kick: assert property (p_kick)
      else $error("kick edge did not clear the watchdog counter");

   // Floating kick input never expires
   property p_float;
      @(posedge clk_in) disable iff (!rstn_in)
      q.flt_s2 && (wd_cnt >= WD_FLOAT_CYC)
         |=> (wd_cnt == 32'h0000_0000) && !wd_hit;
   endproperty
   a_float: assert property (p_float)
      else $error("floating kick input not serviced at 7/8");

   // Undervoltage forces reset
   property p_uv;
      @(posedge clk_in) disable iff (!rstn_in)
      q.uv_s2 |=> (q.st == SRW_ST_FORCE);
   endproperty
   a_uv: assert property (p_uv)
      else $error("undervoltage did not force reset");

   // Hold expiry releases reset
   property p_release;
      @(posedge clk_in) disable iff (!rstn_in)
      (q.st == SRW_ST_HOLD) && hold_hit && !cause
         |=> reset_n_out ##1 (wd_cnt <= 32'h0000_0001);
   endproperty
   a_release: assert property (p_release)
      else $error("hold expiry did not release reset");

   // Pull-up stops at the high level or at the one-shot end
   property p_pu_off;
      @(posedge clk_in) disable iff (!rstn_in)
      q.pu && (q.hi_s2 || os_hit) |=> !q.pu;
   endproperty
   a_pu_off: assert property (p_pu_off)
      else $error("active pull-up not switched off");

   // Passive pull-up off while asserting
   property p_passive;
      @(posedge clk_in) disable iff (!rstn_in)
      !reset_n_out |-> !passive_pullup_out;
   endproperty
   a_passive: assert property (p_passive)
      else $error("passive pull-up connected during reset");

   // Open-drain never drives high
   property p_od;
      @(posedge clk_in) disable iff (!rstn_in)
      (OUT_STYLE == `SRW_STYLE_OD) |-> !line_out
         && (line_oe_out == !reset_n_out);
   endproperty
   a_od: assert property (p_od)
      else $error("open-drain pin driven wrongly");

   // Main scenarios
   c_mr: cover property (@(posedge clk_in) disable iff (!rstn_in)
      (q.st == SRW_ST_FORCE) ##1 (q.st == SRW_ST_HOLD));
   c_wd: cover property (@(posedge clk_in) disable iff (!rstn_in)
      wd_expire && (q.st == SRW_ST_RUN));
   c_rel: cover property (@(posedge clk_in) disable iff (!rstn_in)
      $rose(reset_n_out));
   c_pu: cover property (@(posedge clk_in) disable iff (!rstn_in)
      $rose(q.pu));

endmodule : srw_core

// File: bench/srw_cpu_model.sv
`timescale 1ns/10ps
module srw_cpu_model (
   input wire logic clk_in,
   input wire logic line_in,
   input wire logic line_oe_in,
   input wire logic passive_in,
   input wire logic ext_low_in,
   output logic above_pth_out,
   output logic above_hi_out
);
   logic [4:0] lvl_q;

   // Line charge: any low driver empties it, pull-ups refill it
   always @(posedge clk_in) begin
      if (ext_low_in || (line_oe_in && !line_in)) begin
         lvl_q <= 5'h00;
      end else if (line_oe_in && line_in) begin
         lvl_q <= (lvl_q > 5'h0F) ? 5'h17 : lvl_q + 5'h08;
      end else if (passive_in && lvl_q < 5'h17) begin
         lvl_q <= lvl_q + 5'h01; // Slow rise through the resistor
      end
   end

   // Comparator views of the line level
   assign above_pth_out = (lvl_q >= 5'h02);
   assign above_hi_out = (lvl_q >= 5'h0C);
endmodule : srw_cpu_model

// File: bench/supervisor_reset_watchdog_tb.sv
`timescale 1ns/10ps
`include "srw_defines.svh"
module supervisor_reset_watchdog_tb;
   import srw_pkg::*;
   localparam int HOLD = 20;
   localparam int WD = 100;
   localparam int OS_CYC = `SRW_ONESHOT_CYC;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic uv = 1'b0;
   logic mr_n = 1'b1;
   logic kick = 1'b0;
   logic kick_drv = 1'b0;
   logic flt = 1'b0;
   logic ext_low = 1'b0;
   logic pth, hi;
   logic rn, r, l_out, l_oe, pp;
   logic od_rn, od_r, od_out, od_oe, od_pp;
   logic ps_rn, ps_r, ps_out, ps_oe, ps_pu;
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 9;
   int low_cnt = 0;
   int pu_cnt = 0;
   int n, k;

   always #25 clk_in = ~clk_in;

   srw_core #(.OUT_STYLE(`SRW_STYLE_BIDIR), .HOLD_CYC(32'h0000_0014),
      .WD_CYC(32'h0000_0064)) i_srw_core (.clk_in(clk_in),
      .rstn_in(rstn_in), .undervoltage_in(uv), .manual_reset_n_in(mr_n),
      .watchdog_kick_in(kick), .watchdog_float_in(flt),
      .line_above_pth_in(pth), .line_above_hi_in(hi), .reset_n_out(rn),
      .reset_out(r), .line_out(l_out), .line_oe_out(l_oe),
      .passive_pullup_out(pp));
   srw_core #(.OUT_STYLE(`SRW_STYLE_OD), .HOLD_CYC(32'h0000_0014),
      .WD_CYC(32'h0000_0064)) i_srw_core_od (.clk_in(clk_in),
      .rstn_in(rstn_in), .undervoltage_in(uv), .manual_reset_n_in(mr_n),
      .watchdog_kick_in(kick), .watchdog_float_in(flt),
      .line_above_pth_in(pth), .line_above_hi_in(hi), .reset_n_out(od_rn),
      .reset_out(od_r), .line_out(od_out), .line_oe_out(od_oe),
      .passive_pullup_out(od_pp));
   srw_core #(.OUT_STYLE(`SRW_STYLE_PP), .HOLD_CYC(32'h0000_0014),
      .WD_CYC(32'h0000_0064)) i_srw_core_pp (.clk_in(clk_in),
      .rstn_in(rstn_in), .undervoltage_in(uv), .manual_reset_n_in(mr_n),
      .watchdog_kick_in(kick), .watchdog_float_in(flt),
      .line_above_pth_in(pth), .line_above_hi_in(hi), .reset_n_out(ps_rn),
      .reset_out(ps_r), .line_out(ps_out), .line_oe_out(ps_oe),
      .passive_pullup_out(ps_pu));
   srw_cpu_model i_srw_cpu_model (.clk_in(clk_in), .line_in(l_out),
      .line_oe_in(l_oe), .passive_in(pp), .ext_low_in(ext_low),
      .above_pth_out(pth), .above_hi_out(hi));

   // Floating kick pin shows a changing pattern, else the driven level
   always @(posedge clk_in) begin
      kick <= flt ? ~kick : kick_drv;
   end

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_rng(input string nm, input int a, input int b,
      input int g);
      n_tests++;
      if (g < a || g > b) begin
         error_cnt++;
         $display("mismatch %s expected %0d..%0d seen %0d", nm, a, b, g);
      end
   endtask : chk_rng

   // Latest cycle count allowed after a cause, with sync slack
   function automatic int late(input int base);
      return base + 8;
   endfunction : late

   // Cycles until reset_n_out reaches a level, bounded
   task automatic wait_rn(input logic v, output int c);
      c = 0;
      while (rn !== v && c < 2000) begin
         @(posedge clk_in);
         c++;
      end
   endtask : wait_rn

   // Per-cycle output checks and event counters
   always @(negedge clk_in) begin
      if (rstn_in) begin
         chk_bit("reset_out", ~rn, r);
         chk_bit("od_oe", ~od_rn, od_oe);
         chk_bit("od_reset_out", ~od_rn, od_r);
         chk_bit("od_passive", 1'b0, od_pp);
         chk_bit("pp_reset_out", ~ps_rn, ps_r);
         chk_bit("pp_line", ps_rn, ps_out);
         chk_bit("pp_oe", 1'b1, ps_oe);
         chk_bit("pp_passive", 1'b0, ps_pu);
         chk_bit("pp_vs_od", od_rn, ps_rn);
         if (od_oe) begin
            chk_bit("od_out", 1'b0, od_out);
         end
         if (!rn) begin
            chk_bit("passive", 1'b0, pp);
            chk_bit("line_low", 1'b0, l_out);
            chk_bit("line_oe", 1'b1, l_oe);
            low_cnt++;
         end
         if (l_oe && l_out) begin
            pu_cnt++;
         end
      end
   end

   initial begin
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'b1;
      wait_rn(1'b1, n);
      chk_rng("power_up_hold", HOLD, late(HOLD), n);
      // Random kicks inside the period keep reset away
      k = low_cnt;
      repeat (12) begin
         repeat (10 + $unsigned($random(seed)) % (WD / 2)) @(posedge clk_in);
         kick_drv <= ~kick_drv;
      end
      chk_rng("kicked_lows", 0, 0, low_cnt - k);
      // Two expiries in a row, kick held at each level in turn
      for (int i = 0; i < 2; i++) begin
         wait_rn(1'b0, n);
         chk_rng("wd_expiry", WD, late(WD), n);
         @(posedge clk_in);
         kick_drv <= ~kick_drv;
         wait_rn(1'b1, n);
         chk_rng("wd_hold", HOLD - 1, late(HOLD), n);
      end
      // Floating kick input never times out
      flt <= 1'b1;
      k = low_cnt;
      repeat (4 * WD) @(posedge clk_in);
      chk_rng("float_lows", 0, 0, low_cnt - k);
      // Manual reset, then undervoltage, each of random length
      for (int s = 0; s < 2; s++) begin
         k = 5 + $unsigned($random(seed)) % 40;
         if (s == 0) begin
            mr_n <= 1'b0;
         end else begin
            uv <= 1'b1;
         end
         wait_rn(1'b0, n);
         chk_rng("cause_assert", 2, 5, n);
         repeat (k) @(posedge clk_in);
         chk_bit("cause_held", 1'b0, rn);
         mr_n <= 1'b1;
         uv <= 1'b0;
         pu_cnt = 0;
         wait_rn(1'b1, n);
         chk_rng("cause_hold", HOLD, late(HOLD), n);
         repeat (60) @(posedge clk_in);
         chk_rng("pullup_cyc", 1, 40, pu_cnt);
      end
      // Processor pulls the line low, releases, samples soon after
      for (int j = 0; j < 2; j++) begin
         pu_cnt = 0;
         ext_low <= 1'b1;
         repeat (20 + $unsigned($random(seed)) % 10) @(posedge clk_in);
         ext_low <= 1'b0;
         repeat (10) @(posedge clk_in);
         chk_bit("line_high", 1'b1, hi);
         repeat (50) @(posedge clk_in);
         chk_rng("ext_pullup", 1, 40, pu_cnt);
      end
      // Line pulled low again under the pull-up: only the one-shot ends it
      pu_cnt = 0;
      ext_low <= 1'b1;
      repeat (20) @(posedge clk_in);
      ext_low <= 1'b0;
      repeat (5) @(posedge clk_in);
      ext_low <= 1'b1;
      repeat (60) @(posedge clk_in);
      ext_low <= 1'b0;
      chk_rng("oneshot_cyc", OS_CYC, OS_CYC, pu_cnt);
      repeat (20) @(posedge clk_in);
      finish_test();
   end

   // Whole run needs under 3000 cycles; cut a hang well beyond that
   initial begin
      #(50 * 20000);
      error_cnt++;
      finish_test();
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
endmodule : supervisor_reset_watchdog_tb
